// [hw/sah_host.sv]
// Host-side controller that starts conversions on a self-timed 8-bit
// sampling converter and fetches each result over its strobe pins.
// Assumes the converter's pins are wired straight to these ports, with an
// external pull-up on the shared write/ready line; one 200 MHz clock.
//
// Contract
// R1: Interface-select low gives single-read mode, high gives write-then-read mode.
// R2: Single-read: chip select and read held low until conversion completes and data read.
// R3: Write-then-read: write pulse starts conversion, a later read fetches the result.
// R4: Device samples input on the falling edge of the starting strobe.
// R5: Host leaves at least 350 ns after a conversion before the next start.
// R6: Device tracks input between conversions and holds it during one.
// R7: Write-then-read conversion completes within 660 ns including read access.
// R8: Early-read cycle period gives a maximum sample rate of 1 MHz.
// R9: Each result is one of 256 codes on the eight-bit bus.
// R10: Completion flag goes low at end, released by rising chip select or read.
// R11: Host may read 250 ns after write rises without waiting for completion.
// R12: Data outputs are driven only while read and chip select are low.
// R13: Single-read mode: shared pin is open-drain wait, released at conversion end.
// R14: Host keeps interface-select stable during a conversion.
`timescale 1ns/1ps
`include "sah_defines.svh"

module sah_host #(
    parameter int unsigned TIMEOUT_CYC = `SAH_TIMEOUT_CYC // Wait limit for completion
) (
    input wire logic sys_clk, // 200 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic start, // One-cycle request for a conversion
    input wire logic mode_sel, // 0 single-read, 1 write-then-read
    input wire logic early_read, // Write-then-read: read after fixed delay
    output logic busy, // High while a conversion or gap is running
    output logic done, // One-cycle pulse when result is valid
    output logic timeout, // One-cycle pulse when completion never came
    output logic [`SAH_DATA_W-1:0] result, // Last fetched code
    output logic overrange, // High if last fetched conversion was over range
    output logic cs_n, // Chip select pin, active low
    output logic rd_n, // Read strobe pin, active low
    output logic mode_pin, // Interface-select pin
    input wire logic wr_rdy_in, // Shared write/ready pin, level seen
    output logic wr_rdy_out, // Shared pin, level driven
    output logic wr_rdy_oe, // Shared pin, high while host drives it
    input wire logic done_n, // Completion flag pin, active low
    input wire logic overrange_flag_n, // Overrange pin, active low
    input wire logic [`SAH_DATA_W-1:0] result_bus // Three-state result pins
);

    localparam logic [`SAH_CNT_W-1:0] WR_CYC = `SAH_CNT_W'(`SAH_WR_CYC);
    localparam logic [`SAH_CNT_W-1:0] WR2RD_CYC = `SAH_CNT_W'(`SAH_WR2RD_CYC);
    localparam logic [`SAH_CNT_W-1:0] GAP_CYC = `SAH_CNT_W'(`SAH_GAP_CYC);
    localparam logic [`SAH_CNT_W-1:0] ACC_CYC = `SAH_CNT_W'(`SAH_ACC_CYC);
    localparam logic [`SAH_CNT_W-1:0] TMO_CYC = `SAH_CNT_W'(TIMEOUT_CYC);
    localparam logic [`SAH_CNT_W-1:0] CNT_ONE = `SAH_CNT_W'(1);

    sah_pkg::sah_regs_t r;
    sah_pkg::sah_regs_t next_r;

    logic int_low;
    logic rdy_high;
    logic gap_clear;

    // Synchronised pin levels; only the second stage is looked at
    assign int_low = !r.int_sync[1];
    assign rdy_high = r.rdy_sync[1];
    assign gap_clear = (r.gap == '0);

    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.timeout = 1'b0;

        // Two flip-flops on every pin that comes from the converter
        next_r.int_sync = {r.int_sync[0], done_n};
        next_r.rdy_sync = {r.rdy_sync[0], wr_rdy_in};
        next_r.ovr_sync = {r.ovr_sync[0], overrange_flag_n};
        next_r.bus_sync = {r.bus_sync[`SAH_DATA_W-1:0], result_bus};

        // Inter-conversion gap counts down from each conversion's end
        if (!gap_clear) begin
            next_r.gap = r.gap - CNT_ONE; // [R5]
        end

        case (r.state)
            sah_pkg::SAH_IDLE: begin
                // Mode pin follows the request only while no conversion runs
                next_r.mode_pin = mode_sel; // [R14]
                next_r.wr_oe = mode_sel; // [R13]
                next_r.wr_out = 1'b1;
                next_r.busy = !gap_clear;
                // Start waits for the gap; the pin must have settled a cycle
                if (start && gap_clear && (r.mode_pin == mode_sel)) begin // [R5] [R14]
                    next_r.mode_lat = mode_sel; // [R1]
                    next_r.early_lat = early_read;
                    next_r.busy = 1'b1;
                    next_r.cs_n = 1'b0;
                    next_r.cnt = '0;
                    next_r.rdy_seen_low = 1'b0;
                    if (mode_sel) begin
                        // Falling write edge starts and samples
                        next_r.wr_out = 1'b0; // [R3] [R4]
                        next_r.state = sah_pkg::SAH_WR_PULSE;
                    end else begin
                        // Falling read edge starts and samples
                        next_r.rd_n = 1'b0; // [R2] [R4]
                        next_r.state = sah_pkg::SAH_RD_WAIT;
                    end
                end
            end

            sah_pkg::SAH_RD_WAIT: begin
                // Strobes stay low like a stretched read with wait states
                next_r.cnt = r.cnt + CNT_ONE;
                if (!rdy_high) begin
                    next_r.rdy_seen_low = 1'b1; // [R13]
                end
                // Ready released after it went low, or flag low, ends the wait
                if (int_low || (r.rdy_seen_low && rdy_high)) begin // [R2] [R10] [R13]
                    next_r.cnt = '0;
                    next_r.state = sah_pkg::SAH_RD_ACC;
                end else if (r.cnt >= TMO_CYC) begin
                    next_r.timeout = 1'b1;
                    next_r.state = sah_pkg::SAH_FINISH;
                end
            end

            sah_pkg::SAH_WR_PULSE: begin
                // Write pulse long enough for the upper-nibble compare
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.cnt >= WR_CYC - CNT_ONE) begin // [R7]
                    next_r.wr_out = 1'b1;
                    next_r.cnt = '0;
                    next_r.state = sah_pkg::SAH_WR_WAIT;
                end
            end

            sah_pkg::SAH_WR_WAIT: begin
                // Early read shortens the cycle; else wait for the flag
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.early_lat && (r.cnt >= WR2RD_CYC - CNT_ONE)) begin // [R11] [R8]
                    next_r.rd_n = 1'b0; // [R3] [R12]
                    next_r.cnt = '0;
                    next_r.state = sah_pkg::SAH_RD_ACC;
                end else if (!r.early_lat && int_low && (r.cnt >= WR2RD_CYC - CNT_ONE)) begin // [R10]
                    next_r.rd_n = 1'b0; // [R3] [R12]
                    next_r.cnt = '0;
                    next_r.state = sah_pkg::SAH_RD_ACC;
                end else if (r.cnt >= TMO_CYC) begin
                    next_r.timeout = 1'b1;
                    next_r.state = sah_pkg::SAH_FINISH;
                end
            end

            sah_pkg::SAH_RD_ACC: begin
                // Allow access time plus the two synchroniser stages
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.cnt >= ACC_CYC + CNT_ONE) begin // [R7] [R12]
                    next_r.result = r.bus_sync[2*`SAH_DATA_W-1:`SAH_DATA_W]; // [R9]
                    next_r.overrange = !r.ovr_sync[1];
                    next_r.done = 1'b1;
                    next_r.state = sah_pkg::SAH_FINISH;
                end
            end

            sah_pkg::SAH_FINISH: begin
                // Rising strobes release the flag and end the conversion
                next_r.cs_n = 1'b1; // [R10]
                next_r.rd_n = 1'b1;
                next_r.wr_out = 1'b1;
                next_r.gap = GAP_CYC; // [R5] [R6]
                next_r.busy = 1'b1;
                next_r.state = sah_pkg::SAH_IDLE;
            end

            default: begin
                next_r.state = sah_pkg::SAH_IDLE;
            end
        endcase
    end

    // State register; the shared pin stays undriven until mode is known
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r.state <= sah_pkg::SAH_IDLE;
            r.cnt <= '0;
            r.gap <= GAP_CYC;
            r.mode_lat <= 1'b0;
            r.early_lat <= 1'b0;
            r.rdy_seen_low <= 1'b0;
            r.cs_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.wr_out <= 1'b1;
            r.wr_oe <= 1'b0;
            r.mode_pin <= 1'b0;
            r.busy <= 1'b1;
            r.done <= 1'b0;
            r.timeout <= 1'b0;
            r.result <= '0;
            r.overrange <= 1'b0;
            r.int_sync <= 2'h3;
            r.rdy_sync <= 2'h3;
            r.ovr_sync <= 2'h3;
            r.bus_sync <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Every output straight from the state register
    assign busy = r.busy;
    assign done = r.done;
    assign timeout = r.timeout;
    assign result = r.result;
    assign overrange = r.overrange;
    assign cs_n = r.cs_n;
    assign rd_n = r.rd_n;
    assign mode_pin = r.mode_pin;
    assign wr_rdy_out = r.wr_out;
    assign wr_rdy_oe = r.wr_oe;

endmodule : sah_host

// [hw/sah_defines.svh]
// Timing figures and widths for the sampling converter host controller.
// Assumes a single system clock whose rate is given below in MHz.
`ifndef SAH_DEFINES_SVH
`define SAH_DEFINES_SVH

`define SAH_CLK_MHZ 200
`define SAH_DATA_W 8
`define SAH_CNT_W 16
// Printed times in ns
`define SAH_T_WR_NS 250
`define SAH_T_WR2RD_NS 250
`define SAH_T_GAP_NS 350
`define SAH_T_CONV_NS 660
`define SAH_T_ACC_NS (`SAH_T_CONV_NS - `SAH_T_WR_NS - `SAH_T_WR2RD_NS)
// Least times, rounded up to whole cycles
`define SAH_CYC_MIN(ns) (((ns) * `SAH_CLK_MHZ + 999) / 1000)
`define SAH_WR_CYC `SAH_CYC_MIN(`SAH_T_WR_NS)
`define SAH_WR2RD_CYC `SAH_CYC_MIN(`SAH_T_WR2RD_NS)
`define SAH_GAP_CYC `SAH_CYC_MIN(`SAH_T_GAP_NS)
`define SAH_ACC_CYC `SAH_CYC_MIN(`SAH_T_ACC_NS)
`define SAH_TIMEOUT_CYC 1000

`endif

// [hw/sah_pkg.sv]
// Types for the sampling converter host controller.
// Assumes sah_defines.svh is on the include path.
`include "sah_defines.svh"

package sah_pkg;

    typedef enum logic [2:0] {
        SAH_IDLE = 3'b000,
        SAH_RD_WAIT = 3'b001,
        SAH_WR_PULSE = 3'b010,
        SAH_WR_WAIT = 3'b011,
        SAH_RD_ACC = 3'b100,
        SAH_FINISH = 3'b101
    } sah_state_t;

    typedef struct packed {
        sah_state_t state;
        logic [`SAH_CNT_W-1:0] cnt;
        logic [`SAH_CNT_W-1:0] gap;
        logic mode_lat;
        logic early_lat;
        logic rdy_seen_low;
        logic cs_n;
        logic rd_n;
        logic wr_out;
        logic wr_oe;
        logic mode_pin;
        logic busy;
        logic done;
        logic timeout;
        logic [`SAH_DATA_W-1:0] result;
        logic overrange;
        logic [1:0] int_sync;
        logic [1:0] rdy_sync;
        logic [1:0] ovr_sync;
        logic [2*`SAH_DATA_W-1:0] bus_sync;
    } sah_regs_t;

endpackage : sah_pkg

// [tb/sah_dev.sv]
// Behavioural model of the self-timed sampling converter.
// Assumes the bench resolves the shared write/ready line.
`timescale 1ns/1ps
module sah_dev #(
    parameter int WRITE_TO_DONE_DELAY = 380, // Write rise to flag, ns
    parameter int CONV_NS = 600 // Single-read conversion, ns
) (
    input wire logic cs_n, // Select
    input wire logic rd_n, // Read
    input wire logic mode_pin, // Mode level
    input wire logic wr_line, // Shared line level
    input wire logic stall, // Never complete
    input wire logic [7:0] ain, // Input code
    input wire logic ain_ovr, // Input over range
    output logic done_n, // Completion flag
    output logic overrange_flag_n, // Overrange flag
    output logic rdy_low, // Pulls shared line low
    output logic [7:0] result_bus // Data pins
);
    logic [7:0] held = 8'h00;
    logic ovr = 1'b0;
    logic valid = 1'b0;
    logic rd_sel;
    // Select and read fall in one time step in single-read mode; a combined level never sees a stale select
    assign rd_sel = !cs_n && !rd_n;
    initial begin
        done_n = 1'b1;
        rdy_low = 1'b0;
    end
    // Released pins show the inverse so stale data never matches
    assign result_bus = (!cs_n && !rd_n && valid) ? held : ~held;
    assign overrange_flag_n = !(valid && ovr);
    // Write fall samples and holds the input
    always @(negedge wr_line) begin
        if (!cs_n && mode_pin) {held, ovr, valid} = {ain, ain_ovr, 1'b0};
    end
    // Self-timed completion after write rises
    always @(posedge wr_line) begin
        if (!cs_n && mode_pin && !stall) begin
            #(WRITE_TO_DONE_DELAY);
            if (!valid) {valid, done_n} = 2'b10;
        end
    end
    // Read fall: starts a single-read conversion, or latches early
    always @(posedge rd_sel) begin
        if (!cs_n && !mode_pin) begin
            {held, ovr, valid, rdy_low} = {ain, ain_ovr, 2'b01};
            if (!stall) begin
                #(CONV_NS);
                {rdy_low, valid, done_n} = 3'b010;
            end
        end else if (!cs_n && !valid && !stall) begin
            {valid, done_n} = 2'b10;
        end
    end
    // Flag and wait output let go on select or read rise
    always @(posedge cs_n or posedge rd_n) {done_n, rdy_low} = 2'b10;
endmodule : sah_dev

// [tb/sah_chk_sva.sv]
// Pin-level checks on the host controller.
// Assumes it is bound into sah_host; one clock.
`timescale 1ns/1ps
`include "sah_defines.svh"
module sah_chk (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic done, // Done pulse
    input wire logic timeout, // Timeout pulse
    input wire logic cs_n, // Select
    input wire logic rd_n, // Read
    input wire logic mode_pin, // Mode level
    input wire logic wr_rdy_out, // Write level
    input wire logic wr_rdy_oe // Write enable
);
    localparam int WR_CYC = `SAH_WR_CYC;
    localparam int WR2RD_CYC = `SAH_WR2RD_CYC;
    localparam int GAP_CYC = `SAH_GAP_CYC;
    logic [15:0] low_cnt, hi_cnt, idle_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Run lengths; counters beat long repetitions
    always_ff @(posedge sys_clk) begin
        low_cnt <= (wr_rdy_oe && !wr_rdy_out) ? low_cnt + 16'h1 : 16'h0;
        hi_cnt <= (rst || (wr_rdy_oe && !wr_rdy_out)) ? 16'h0 : hi_cnt + 16'h1;
        idle_cnt <= (rst || !cs_n) ? 16'h0 : idle_cnt + 16'h1;
    end
    a_mode_hold: assert property (!cs_n |-> $stable(mode_pin)) else $error("mode moved");
    a_pin_role: assert property (!cs_n |-> wr_rdy_oe == mode_pin) else $error("pin role");
    a_rd_start: assert property ($fell(cs_n) && !mode_pin |-> !rd_n) else $error("read start");
    a_wr_start: assert property ($fell(cs_n) && mode_pin |-> !wr_rdy_out && rd_n) else $error("wr start");
    a_rd_release: assert property ($rose(rd_n) |-> $past(done) || timeout || $past(timeout))
        else $error("read left early");
    a_done_read: assert property (done |-> !cs_n && !rd_n) else $error("done off read");
    a_wr_width: assert property ($rose(wr_rdy_out) && wr_rdy_oe |-> low_cnt >= WR_CYC)
        else $error("write short");
    a_wr_to_rd: assert property ($fell(rd_n) && mode_pin |-> hi_cnt >= WR2RD_CYC)
        else $error("read too soon");
    a_gap_min: assert property ($fell(cs_n) |-> idle_cnt >= GAP_CYC) else $error("gap short");
    c_wr_done: cover property (done && mode_pin);
    c_rd_done: cover property (done && !mode_pin);
    c_early: cover property ($fell(rd_n) && mode_pin && hi_cnt < 16'h3C);
    c_timeout: cover property (timeout);
endmodule : sah_chk
bind sah_host sah_chk sah_chk_inst (.sys_clk(sys_clk), .rst(rst), .done(done), .timeout(timeout),
    .cs_n(cs_n), .rd_n(rd_n), .mode_pin(mode_pin), .wr_rdy_out(wr_rdy_out), .wr_rdy_oe(wr_rdy_oe));

// [tb/tb.sv]
// Self-checking bench: host controller against the converter model.
// Assumes sah_host, sah_dev and the bound checker are compiled.
`timescale 1ns/1ps
`include "sah_defines.svh"
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic mode_sel = 1'b0;
    logic early_read = 1'b0;
    logic stall = 1'b0;
    logic ain_ovr = 1'b0;
    logic [7:0] ain = 8'h00;
    logic busy, done, timeout, overrange, cs_n, rd_n, mode_pin, wr_rdy_out, wr_rdy_oe;
    logic done_n, overrange_flag_n, rdy_low, wr_line;
    logic [`SAH_DATA_W-1:0] result, result_bus;
    int error_cnt = 0;
    int samples_checked = 0;
    // Shared line: host drive, else device pull-down, else pull-up
    assign wr_line = wr_rdy_oe ? wr_rdy_out : !rdy_low;
    sah_host #(.TIMEOUT_CYC(200)) sah_host_inst (.sys_clk(sys_clk), .rst(rst), .start(start),
        .mode_sel(mode_sel), .early_read(early_read), .busy(busy), .done(done), .timeout(timeout),
        .result(result), .overrange(overrange), .cs_n(cs_n), .rd_n(rd_n), .mode_pin(mode_pin),
        .wr_rdy_in(wr_line), .wr_rdy_out(wr_rdy_out), .wr_rdy_oe(wr_rdy_oe), .done_n(done_n),
        .overrange_flag_n(overrange_flag_n), .result_bus(result_bus));
    sah_dev sah_dev_inst (.cs_n(cs_n), .rd_n(rd_n), .mode_pin(mode_pin), .wr_line(wr_line),
        .stall(stall), .ain(ain), .ain_ovr(ain_ovr), .done_n(done_n),
        .overrange_flag_n(overrange_flag_n), .rdy_low(rdy_low), .result_bus(result_bus));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // Expected word: code and flag present at the start strobe
    function automatic logic [8:0] expect_word(input logic [7:0] code, input logic o);
        return {o, code};
    endfunction : expect_word
    // One conversion; the input moves five cycles after the start strobe falls to prove it was held
    task automatic convert(input logic m, input logic e, input logic [7:0] code, input logic o, input logic st);
        int n;
        logic [8:0] prev;
        prev = {overrange, result};
        @(posedge sys_clk);
        mode_sel <= m;
        early_read <= e;
        stall <= st;
        ain <= code;
        ain_ovr <= o;
        for (n = 0; n < 400 && (busy !== 1'b0 || mode_pin !== m); n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n >= 400) begin
            check("idle wait", 9'h001, 9'h000);
            complete_run();
        end
        @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ain <= ~code;
        ain_ovr <= ~o;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        for (n = 0; n < 400 && done !== 1'b1 && timeout !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n >= 400) begin
            check("done wait", 9'h001, 9'h000);
            complete_run();
        end
        check("timeout", {8'h00, timeout}, {8'h00, st});
        check("busy", {8'h00, busy}, 9'h001);
        check("result", {overrange, result}, st ? prev : expect_word(code, o));
    endtask : convert
    initial begin
        void'($urandom(32'hD4DB));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        // Corner codes in each mode and read style, then a stalled device
        convert(1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        convert(1'b1, 1'b1, 8'hFF, 1'b1, 1'b0);
        convert(1'b1, 1'b0, 8'h80, 1'b0, 1'b0);
        convert(1'b0, 1'b0, 8'h7F, 1'b1, 1'b1);
        repeat (24) convert(1'($urandom), 1'($urandom), 8'($urandom), 1'($urandom), 1'b0);
        complete_run();
    end
endmodule : tb
